/* File: rtl/twp_regs.svh */
`ifndef TWP_REGS_SVH
`define TWP_REGS_SVH

// Special-function addresses of the unlock key and the guarded registers.
`define TWP_KEY_ADDR 8'hc7
`define TWP_WDOG_CTRL_ADDR 8'hd8
`define TWP_EXTFLAG_ADDR 8'he9
`define TWP_PAGECTL_ADDR 8'hea
`define TWP_PROGSIZE_ADDR 8'heb
`define TWP_FLASHCMD_ADDR 8'hec

// Key values.
`define TWP_KEY_FIRST 8'haa
`define TWP_KEY_SECOND 8'h55

// Guarded bit masks per register.
`define TWP_WDOG_CTRL_GUARD 8'h4b
`define TWP_EXTFLAG_GUARD 8'h01
`define TWP_PAGECTL_GUARD 8'he0
`define TWP_PROGSIZE_GUARD 8'h0f
`define TWP_FLASHCMD_GUARD 8'h0f

// Field positions in the watchdog control register.
`define TWP_WD_RESTART_BIT 0
`define TWP_WD_RESET_EN_BIT 1
`define TWP_WD_IRQ_FLAG_BIT 3
`define TWP_WD_POWERON_BIT 6

// Reset values.
`define TWP_REG_RESET 8'h00
`define TWP_RDATA_RESET 8'h00

// Timing: both limits are three memory cycles; one memory cycle is one clock.
`define TWP_KEY_GAP_MCYC 3
`define TWP_WINDOW_MCYC 3
`define TWP_CLK_PER_MCYC 1
`define TWP_KEY_GAP_CYC (`TWP_KEY_GAP_MCYC * `TWP_CLK_PER_MCYC)
`define TWP_WINDOW_CYC (`TWP_WINDOW_MCYC * `TWP_CLK_PER_MCYC)

`define TWP_NUM_REGS 5

`endif

/* File: rtl/twp_pkg.sv */
package twp_pkg;

  typedef enum logic [2:0] {
    TWP_IDLE = 3'b001,
    TWP_ARMED = 3'b010,
    TWP_OPEN = 3'b100
  } twp_state_type;

  typedef logic [7:0] twp_byte_type;

endpackage

/* File: rtl/twp_guard_bank.sv */
`include "twp_regs.svh"

module twp_guard_bank (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Write side, one enable per register.
  input wire logic [`TWP_NUM_REGS-1:0] wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] wr_mask_in,
  // Hardware set and clear, eight bits per register.
  input wire logic [8*`TWP_NUM_REGS-1:0] hw_set_in,
  input wire logic [8*`TWP_NUM_REGS-1:0] hw_clr_in,
  // Stored contents.
  output logic [8*`TWP_NUM_REGS-1:0] regs_out
);

  genvar i;
  generate
    for (i = 0; i < `TWP_NUM_REGS; i++)
    begin : g_reg
      logic [7:0] q_q;
      logic [7:0] q_d;
      logic [7:0] wm;
      assign wm = wr_en_in[i] ? wr_mask_in : 8'h00;
      // A hardware set wins over any clear or write landing in the same cycle.
      assign q_d = ((q_q & ~hw_clr_in[8*i +: 8]) & ~wm) | (wr_data_in & wm) | hw_set_in[8*i +: 8];
      always_ff @(posedge mclk_in)
      begin
        if (rst_in)
          q_q <= `TWP_REG_RESET;
        else
          q_q <= q_d;
      end
      assign regs_out[8*i +: 8] = q_q;
    end
  endgenerate

endmodule // twp_guard_bank

/* File: rtl/twp_guard.sv */
`include "twp_regs.svh"

module twp_guard (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Special-function byte port.
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // Bit set and clear port.
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_val_in,
  input wire logic bit_wr_in,
  // Hardware events.
  input wire logic wdt_flag_set_in,
  input wire logic por_set_in,
  // Guarded register contents.
  output logic [7:0] watchdog_control_register_out,
  output logic [7:0] ext_flag_out,
  output logic [7:0] page_ctrl_out,
  output logic [7:0] prog_size_out,
  output logic [7:0] flash_cmd_out,
  // Status.
  output logic window_open_out,
  output logic refused_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Write decode.

  twp_pkg::twp_state_type state_q;
  twp_pkg::twp_state_type state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic refused_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  wire bit_valid = bit_wr_in & bit_addr_in[7] & ~sfr_wr_in;
  wire [7:0] bit_reg_addr = {bit_addr_in[7:3], 3'b000};
  wire [7:0] bit_lane = 8'h01 << bit_addr_in[2:0];
  wire wr_any = sfr_wr_in | bit_valid;
  wire [7:0] wr_addr = sfr_wr_in ? sfr_addr_in : bit_reg_addr;
  wire [7:0] wr_data = sfr_wr_in ? sfr_wdata_in : {8{bit_val_in}};
  wire [7:0] wr_lane = sfr_wr_in ? 8'hff : bit_lane;

  // The key register takes only whole-byte writes.
  wire key_wr = sfr_wr_in && (sfr_addr_in == `TWP_KEY_ADDR);
  wire key_first = key_wr && (sfr_wdata_in == `TWP_KEY_FIRST);
  wire key_second = key_wr && (sfr_wdata_in == `TWP_KEY_SECOND);
  wire is_armed = (state_q == twp_pkg::TWP_ARMED);
  wire is_open = (state_q == twp_pkg::TWP_OPEN);

  wire [`TWP_NUM_REGS-1:0] hit;
  assign hit[0] = wr_any && (wr_addr == `TWP_WDOG_CTRL_ADDR);
  assign hit[1] = wr_any && (wr_addr == `TWP_EXTFLAG_ADDR);
  assign hit[2] = wr_any && (wr_addr == `TWP_PAGECTL_ADDR);
  assign hit[3] = wr_any && (wr_addr == `TWP_PROGSIZE_ADDR);
  assign hit[4] = wr_any && (wr_addr == `TWP_FLASHCMD_ADDR);

  wire [7:0] guard_sel =
    hit[0] ? `TWP_WDOG_CTRL_GUARD :
    hit[1] ? `TWP_EXTFLAG_GUARD :
    hit[2] ? `TWP_PAGECTL_GUARD :
    hit[3] ? `TWP_PROGSIZE_GUARD :
    hit[4] ? `TWP_FLASHCMD_GUARD : 8'h00;

  // Guarded lanes pass only while the window is open; other lanes always pass.
  wire [7:0] wr_mask = wr_lane & (is_open ? 8'hff : ~guard_sel);
  wire refuse_now = (|hit) && !is_open && (|(wr_lane & guard_sel));

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequencer.

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (key_first)
    begin
      // A fresh first key always restarts arming, even mid-sequence.
      state_d = twp_pkg::TWP_ARMED;
      cnt_d = 2'(`TWP_KEY_GAP_CYC);
    end
    else
    begin
      case (state_q)
        twp_pkg::TWP_IDLE:
        begin
          cnt_d = 2'd0;
        end
        twp_pkg::TWP_ARMED:
        begin
          if (key_second)
          begin
            state_d = twp_pkg::TWP_OPEN;
            cnt_d = 2'(`TWP_WINDOW_CYC);
          end
          else if (key_wr || cnt_q == 2'd1)
          begin
            state_d = twp_pkg::TWP_IDLE;
            cnt_d = 2'd0;
          end
          else
            cnt_d = cnt_q - 2'd1;
        end
        twp_pkg::TWP_OPEN:
        begin
          if (cnt_q == 2'd1)
          begin
            state_d = twp_pkg::TWP_IDLE;
            cnt_d = 2'd0;
          end
          else
            cnt_d = cnt_q - 2'd1;
        end
        default:
        begin
          state_d = twp_pkg::TWP_IDLE;
          cnt_d = 2'd0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_q <= twp_pkg::TWP_IDLE;
      cnt_q <= 2'd0;
      refused_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      refused_q <= refuse_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guarded storage.

  logic [8*`TWP_NUM_REGS-1:0] regs;
  wire [7:0] wd_q = regs[7:0];
  // The restart bit clears itself after one cycle so it acts as a single kick.
  wire [7:0] wd_set = ({7'h00, wdt_flag_set_in} << `TWP_WD_IRQ_FLAG_BIT)
                    | ({7'h00, por_set_in} << `TWP_WD_POWERON_BIT);
  wire [7:0] wd_clr = {7'h00, wd_q[`TWP_WD_RESTART_BIT]} << `TWP_WD_RESTART_BIT;

  twp_guard_bank u_bank (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wr_en_in(hit),
    .wr_data_in(wr_data),
    .wr_mask_in(wr_mask),
    .hw_set_in({32'h0, wd_set}),
    .hw_clr_in({32'h0, wd_clr}),
    .regs_out(regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path; the key register reads back the sequencer state.

  wire [7:0] key_status = {6'h00, is_open, is_armed};
  assign rdata_d =
    !sfr_rd_in ? `TWP_RDATA_RESET :
    (sfr_addr_in == `TWP_KEY_ADDR) ? key_status :
    (sfr_addr_in == `TWP_WDOG_CTRL_ADDR) ? regs[7:0] :
    (sfr_addr_in == `TWP_EXTFLAG_ADDR) ? regs[15:8] :
    (sfr_addr_in == `TWP_PAGECTL_ADDR) ? regs[23:16] :
    (sfr_addr_in == `TWP_PROGSIZE_ADDR) ? regs[31:24] :
    (sfr_addr_in == `TWP_FLASHCMD_ADDR) ? regs[39:32] : `TWP_RDATA_RESET;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rdata_q <= `TWP_RDATA_RESET;
    else
      rdata_q <= rdata_d;
  end

  assign sfr_rdata_out = rdata_q;
  assign watchdog_control_register_out = regs[7:0];
  assign ext_flag_out = regs[15:8];
  assign page_ctrl_out = regs[23:16];
  assign prog_size_out = regs[31:24];
  assign flash_cmd_out = regs[39:32];
  assign window_open_out = is_open;
  assign refused_out = refused_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  wire wd_reset_en = regs[`TWP_WD_RESET_EN_BIT];
  wire flash_wr = sfr_wr_in && (sfr_addr_in == `TWP_FLASHCMD_ADDR);

  property p_open_after_key;
    @(posedge mclk_in) disable iff (rst_in)
    key_first ##1 key_second ##1 !key_first ##1 !key_first
      |=> is_open && $past(is_open) && $past(is_open, 2);
  endproperty
  a_open_after_key: assert property (p_open_after_key) else $error("window did not open");

  property p_window_len;
    @(posedge mclk_in) disable iff (rst_in)
    (is_open && !key_first)[*3] |=> !is_open;
  endproperty
  a_window_len: assert property (p_window_len) else $error("window open too long");

  property p_abort;
    @(posedge mclk_in) disable iff (rst_in)
    is_armed && key_wr && !key_first && !key_second |=> state_q == twp_pkg::TWP_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("partial sequence kept");

  property p_closed_hold;
    @(posedge mclk_in) disable iff (rst_in)
    !is_open |=> (prog_size_out & `TWP_PROGSIZE_GUARD) == ($past(prog_size_out) & `TWP_PROGSIZE_GUARD)
      && (page_ctrl_out & `TWP_PAGECTL_GUARD) == ($past(page_ctrl_out) & `TWP_PAGECTL_GUARD);
  endproperty
  a_closed_hold: assert property (p_closed_hold) else $error("guarded bit changed while closed");

  property p_late_key;
    @(posedge mclk_in) disable iff (rst_in)
    key_first ##1 !key_wr[*3] ##1 key_second |=> !is_open;
  endproperty
  a_late_key: assert property (p_late_key) else $error("late second key opened window");

  property p_late_write;
    @(posedge mclk_in) disable iff (rst_in)
    is_armed && key_second ##1 !key_wr[*3] ##1 flash_wr
      |=> (flash_cmd_out & `TWP_FLASHCMD_GUARD) == ($past(flash_cmd_out) & `TWP_FLASHCMD_GUARD);
  endproperty
  a_late_write: assert property (p_late_write) else $error("late guarded write taken");

  property p_second_late;
    @(posedge mclk_in) disable iff (rst_in)
    is_armed && key_second ##1 (!key_wr && !flash_wr)[*2] ##1 (flash_wr && !key_wr) ##1 flash_wr
      |=> $stable(flash_cmd_out[3:0]);
  endproperty
  a_second_late: assert property (p_second_late) else $error("second late write taken");

  property p_bit_clear;
    @(posedge mclk_in) disable iff (rst_in)
    bit_wr_in && !sfr_wr_in && bit_addr_in == 8'hd9 && !is_open |=> $stable(wd_reset_en);
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("enable cleared without window");

  property p_ewt_kept;
    @(posedge mclk_in) disable iff (rst_in)
    wd_reset_en && !is_open |=> wd_reset_en;
  endproperty
  a_ewt_kept: assert property (p_ewt_kept) else $error("enable dropped while closed");

  property p_accept;
    @(posedge mclk_in) disable iff (rst_in)
    is_open && flash_wr |=> flash_cmd_out == $past(sfr_wdata_in);
  endproperty
  a_accept: assert property (p_accept) else $error("open window write lost");

  property p_reset;
    @(posedge mclk_in) rst_in |=> state_q == twp_pkg::TWP_IDLE && !window_open_out;
  endproperty
  a_reset: assert property (p_reset) else $error("not idle after reset");

  c_open: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(is_open));
  c_accept: cover property (@(posedge mclk_in) disable iff (rst_in) is_open && flash_wr);
  c_refuse: cover property (@(posedge mclk_in) disable iff (rst_in) refuse_now && hit[0]);
  c_abort: cover property (@(posedge mclk_in) disable iff (rst_in) is_armed && key_wr && !key_second);

endmodule // twp_guard

/* File: dv/twp_core_model.sv */
`include "twp_regs.svh"

module twp_core_model (
  // Clock.
  input wire logic mclk_in,
  // Byte port.
  output logic [7:0] sfr_addr_out,
  output logic [7:0] sfr_wdata_out,
  output logic sfr_wr_out,
  output logic sfr_rd_out,
  // Bit port.
  output logic [7:0] bit_addr_out,
  output logic bit_val_out,
  output logic bit_wr_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sfr_addr_out = 8'h00;
    sfr_wdata_out = 8'h00;
    sfr_wr_out = 1'b0;
    sfr_rd_out = 1'b0;
    bit_addr_out = 8'h00;
    bit_val_out = 1'b0;
    bit_wr_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One instruction cycle per call: 0 idle, 1 byte write, 2 read, 3 bit write.
  task automatic op(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    sfr_addr_out <= a;
    sfr_wdata_out <= d;
    sfr_wr_out <= (k == 2'h1);
    sfr_rd_out <= (k == 2'h2);
    bit_addr_out <= a;
    bit_val_out <= d[0];
    bit_wr_out <= (k == 2'h3);
  endtask

  // Software opens the window with two back-to-back key writes.
  task automatic unlock();
    op(2'h1, `TWP_KEY_ADDR, `TWP_KEY_FIRST);
    op(2'h1, `TWP_KEY_ADDR, `TWP_KEY_SECOND);
  endtask
endmodule // twp_core_model

/* File: dv/timed_write_protection_window_tb.sv */
`include "twp_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module timed_write_protection_window_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ADR [5] = '{`TWP_WDOG_CTRL_ADDR, `TWP_EXTFLAG_ADDR, `TWP_PAGECTL_ADDR,
    `TWP_PROGSIZE_ADDR, `TWP_FLASHCMD_ADDR};
  localparam logic [7:0] MSK [5] = '{`TWP_WDOG_CTRL_GUARD, `TWP_EXTFLAG_GUARD, `TWP_PAGECTL_GUARD,
    `TWP_PROGSIZE_GUARD, `TWP_FLASHCMD_GUARD};
  localparam logic [7:0] ATAB [8] = '{8'hc7, 8'hc7, 8'hd8, 8'he9, 8'hea, 8'heb, 8'hec, 8'h40};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, rdata, wdc, extf, pgc, psz, fcm, e_rd;
  logic sfr_wr, sfr_rd, bit_val, bit_wr, win_o, ref_o, e_ref;
  logic [7:0] rg [5];
  logic wdt_set = 1'b0;
  logic por_set = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int seed = 36553;
  int arm, win;

  always #25 mclk_in = ~mclk_in;

  twp_core_model core (.mclk_in(mclk_in), .sfr_addr_out(sfr_addr), .sfr_wdata_out(sfr_wdata),
    .sfr_wr_out(sfr_wr), .sfr_rd_out(sfr_rd), .bit_addr_out(bit_addr), .bit_val_out(bit_val),
    .bit_wr_out(bit_wr));

  twp_guard uut (.mclk_in(mclk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr), .sfr_wdata_in(sfr_wdata),
    .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .sfr_rdata_out(rdata), .bit_addr_in(bit_addr),
    .bit_val_in(bit_val), .bit_wr_in(bit_wr), .wdt_flag_set_in(wdt_set), .por_set_in(por_set),
    .watchdog_control_register_out(wdc), .ext_flag_out(extf), .page_ctrl_out(pgc),
    .prog_size_out(psz), .flash_cmd_out(fcm), .window_open_out(win_o), .refused_out(ref_o));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic int idx_of(input logic [7:0] a);
    for (int i = 0; i < 5; i++)
      if (ADR[i] == a)
        return i;
    return -1;
  endfunction

  // Reference model: arm counts key cycles, win counts open window cycles left.
  always @(posedge mclk_in)
  begin : model
    int i;
    logic [7:0] m;
    logic op;
    logic kw;
    if (rst_in)
    begin
      arm = 0;
      win = 0;
      e_rd = 8'h00;
      e_ref = 1'b0;
      foreach (rg[j]) rg[j] = 8'h00;
    end
    else
    begin
      op = win > 0;
      i = idx_of(sfr_addr);
      e_ref = 1'b0;
      e_rd = 8'h00;
      if (sfr_rd)
        e_rd = (sfr_addr == `TWP_KEY_ADDR) ? {6'h00, op, arm > 0} : ((i >= 0) ? rg[i] : 8'h00);
      rg[0][`TWP_WD_RESTART_BIT] = 1'b0;
      kw = sfr_wr && sfr_addr == `TWP_KEY_ADDR;
      if (kw && sfr_wdata == `TWP_KEY_FIRST)
      begin
        arm = 1;
        win = 0;
      end
      else if (kw && arm > 0 && sfr_wdata == `TWP_KEY_SECOND)
      begin
        arm = 0;
        win = `TWP_WINDOW_CYC;
      end
      else
      begin
        arm = (kw || arm == 0 || arm >= `TWP_KEY_GAP_CYC) ? 0 : arm + 1;
        win = (win > 0) ? win - 1 : 0;
      end
      if (sfr_wr && i >= 0)
      begin
        m = op ? 8'h00 : MSK[i];
        rg[i] = (rg[i] & m) | (sfr_wdata & ~m);
        e_ref = !op;
      end
      i = idx_of(bit_addr & 8'hf8);
      if (bit_wr && !sfr_wr && bit_addr[7] && i >= 0)
      begin
        m = 8'h01 << bit_addr[2:0];
        e_ref = !op && (MSK[i] & m) != 8'h00;
        if (!e_ref)
          rg[i] = bit_val ? (rg[i] | m) : (rg[i] & ~m);
      end
      // Hardware flag events come last so that they win over any write in the same cycle.
      if (wdt_set)
        rg[0][`TWP_WD_IRQ_FLAG_BIT] = 1'b1;
      if (por_set)
        rg[0][`TWP_WD_POWERON_BIT] = 1'b1;
    end
  end

  always @(negedge mclk_in)
  begin
    `CHK({wdc, extf, pgc, psz, fcm}, {rg[0], rg[1], rg[2], rg[3], rg[4]})
    `CHK(win_o, win > 0)
    `CHK(ref_o, e_ref)
    `CHK(rdata, e_rd)
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic idle(input int n);
    repeat (n) core.op(2'h0, 8'($random(seed)), 8'($random(seed)));
  endtask

  task automatic final_report();
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // The run needs about 630 cycles; the limit leaves ample margin.
  initial
  begin
    #150000;
    n_errors++;
    final_report();
  end

  initial
  begin : main
    logic [31:0] r;
    logic [7:0] a;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    core.op(2'h1, `TWP_FLASHCMD_ADDR, 8'hff);
    idle(2);
    core.unlock();
    core.op(2'h1, `TWP_FLASHCMD_ADDR, 8'h0a);
    foreach (ADR[j])
    begin
      core.unlock();
      core.op(2'h1, ADR[j], 8'hff);
      core.op(2'h2, ADR[j], 8'h00);
    end
    for (int g = 1; g <= 4; g++)
    begin
      core.op(2'h1, `TWP_KEY_ADDR, `TWP_KEY_FIRST);
      idle(g - 1);
      core.op(2'h1, `TWP_KEY_ADDR, `TWP_KEY_SECOND);
      core.op(2'h1, `TWP_PROGSIZE_ADDR, 8'(g));
    end
    for (int g = 0; g <= 4; g++)
    begin
      core.unlock();
      idle(g);
      core.op(2'h1, `TWP_EXTFLAG_ADDR, 8'(g));
    end
    core.unlock();
    repeat (4) core.op(2'h1, `TWP_PAGECTL_ADDR, 8'($random(seed)));
    core.unlock();
    idle(2);
    repeat (2) core.op(2'h1, `TWP_FLASHCMD_ADDR, 8'($random(seed)));
    core.unlock();
    idle(3);
    core.op(2'h1, `TWP_FLASHCMD_ADDR, 8'($random(seed)));
    core.op(2'h1, `TWP_KEY_ADDR, `TWP_KEY_FIRST);
    core.op(2'h1, `TWP_KEY_ADDR, 8'h12);
    core.op(2'h1, `TWP_KEY_ADDR, `TWP_KEY_SECOND);
    core.op(2'h1, `TWP_FLASHCMD_ADDR, 8'h05);
    core.unlock();
    core.op(2'h3, 8'hd9, 8'h01);
    idle(4);
    core.op(2'h3, 8'hd9, 8'h00);
    idle(2);
    `CHK(wdc[`TWP_WD_RESET_EN_BIT], 1'b1)
    core.unlock();
    rst_in <= 1'b1;
    idle(2);
    rst_in <= 1'b0;
    core.op(2'h1, `TWP_FLASHCMD_ADDR, 8'hff);
    repeat (500)
    begin
      r = $random(seed);
      wdt_set <= (r[31:29] == 3'h7);
      por_set <= (r[28:26] == 3'h7);
      a = ATAB[r[4:2]];
      if (r[1:0] == 2'h3)
        a = {a[7:3], r[7:5]};
      core.op(r[1:0], a, (a != `TWP_KEY_ADDR) ? r[23:16] :
        (r[8] ? `TWP_KEY_FIRST : (r[9] ? `TWP_KEY_SECOND : r[23:16])));
    end
    wdt_set <= 1'b0;
    por_set <= 1'b0;
    idle(2);
    final_report();
  end
endmodule // timed_write_protection_window_tb
